// File: rtl/itb_pkg.sv
// Constants, types and field layout for the interrupt and time base block
//
// Summary of operation
// - Comparator output change sets comparator flag
// - Vector only with global, source enable, stack room
// - Comparator service clears its flag and global enable
// - Five multifunction groups built from peripheral requests
// - Any grouped source request sets multifunction flag
// - Group service clears only group flag, global enable
// - Finished conversion sets converter flag
// - Converter service clears its flag and global enable
// - Divider overflow sets time base flags
// - Time base service clears its flag, global enable
// - Time base runs only while run bit set
// - Clock select picks sub clock or system/4
// - Time base one period 4096 to 32768 clocks
// - Time base zero period 256 doubling to 32768
// - Control bit 3 drives crystal low power mode
// - Memory write cycle end sets memory flag
// - Memory vector needs global, own, group enables
// - Low supply report sets low voltage flag
// - Serial module byte done sets its flag
// - Secondary port byte done sets its flag
// - Any flag rising wakes device regardless enables
// - Interrupt return sets global enable again
package itb_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_ENABLE_OFS = 8'h00;
  localparam logic [7:0] REG_FLAGS_OFS  = 8'h04;
  localparam logic [7:0] REG_GLOBAL_OFS = 8'h08;
  localparam logic [7:0] REG_GROUP4_OFS = 8'h0c;
  localparam logic [7:0] REG_TB_CTL_OFS = 8'h10;
  localparam logic [7:0] REG_STATUS_OFS = 8'h14;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int NUM_SRC        = 9;
  localparam int NUM_GROUP      = 5;
  localparam int GLOBAL_EN_BIT  = 0;
  localparam int GLOBAL_STK_BIT = 1;
  localparam int GRP_LOWV_EN    = 0;
  localparam int GRP_EEP_EN     = 1;
  localparam int GRP_SER_EN     = 2;
  localparam int GRP_SPI2_EN    = 3;
  localparam int GRP_FLAG_LSB   = 4;
  localparam int TB_RUN_BIT     = 7;
  localparam int TB_CKSEL_BIT   = 6;
  localparam int TB_ONE_LSB     = 4;
  localparam int TB_LXT_LP_BIT  = 3;
  localparam int TB_ZERO_LSB    = 0;
  localparam int STAT_CMP_BIT   = 16;
  localparam int STAT_VEC_LSB   = 24;
  localparam logic [7:0] TB_CTL_RESET = 8'h37;
  localparam logic [8:0] ENABLE_RESET = 9'h000;
  localparam logic [8:0] FLAGS_RESET  = 9'h000;
  localparam logic [3:0] GROUP_RESET  = 4'h0;

  // ----------------------------------------------------------------
  // Time base divider
  // ----------------------------------------------------------------
  localparam int TB_CNT_W = 15;
  localparam logic [14:0] TB_FULL_MASK = 15'h7fff;
  localparam logic [2:0]  TB_ZERO_MAXC = 3'h7;
  localparam logic [1:0]  TB_ONE_MAXC  = 2'h3;
  localparam logic [1:0]  SYS_PRESC_LAST = 2'h3;

  // ----------------------------------------------------------------
  // Sources in priority order, index 0 highest
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    SRC_CMP  = 4'h0,
    SRC_GRP0 = 4'h1,
    SRC_GRP1 = 4'h2,
    SRC_GRP2 = 4'h3,
    SRC_GRP3 = 4'h4,
    SRC_GRP4 = 4'h5,
    SRC_ADC  = 4'h6,
    SRC_TB0  = 4'h7,
    SRC_TB1  = 4'h8
  } itb_src_t;

  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_ACK  = 1'b1
  } itb_bus_st_t;

  // Peripheral event carrier, all same clock
  typedef struct packed {
    logic [3:0] timer_grp_req;
    logic       adc_done;
    logic       eep_wr_done;
    logic       serial_done;
    logic       spi2_done;
  } itb_evt_t;

endpackage

// File: rtl/itb_tb_div.sv
// Time base divider with two selectable overflow taps
`timescale 1ns/1ps
module itb_tb_div (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        clk_en,
  input  wire logic        run,
  input  wire logic        tick,
  input  wire logic [2:0]  zero_period,
  input  wire logic [1:0]  one_period,
  output logic             zero_ovf,
  output logic             one_ovf,
  output logic [14:0]      count
);

  logic [14:0] cnt_ff;
  logic [14:0] zero_mask;
  logic [14:0] one_mask;

  // ----------------------------------------------------------------
  // Counter, cleared while stopped
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_ff <= 15'h0000;
    end else if (clk_en) begin
      if (!run) begin
        cnt_ff <= 15'h0000;
      end else if (tick) begin
        cnt_ff <= cnt_ff + 15'h0001;
      end
    end
  end

  // Tap masks: 256..32768 and 4096..32768 clocks
  assign zero_mask = itb_pkg::TB_FULL_MASK
                     >> (itb_pkg::TB_ZERO_MAXC - zero_period);
  assign one_mask  = itb_pkg::TB_FULL_MASK
                     >> (itb_pkg::TB_ONE_MAXC - one_period);

  // Overflow on the tick that wraps the tap
  assign zero_ovf = run && tick && ((cnt_ff & zero_mask) == zero_mask);
  assign one_ovf  = run && tick && ((cnt_ff & one_mask) == one_mask);
  assign count    = cnt_ff;

endmodule

// File: rtl/itb_irq_ctrl.sv
// Interrupt request flags, vectoring and time base with Avalon registers
`timescale 1ns/1ps
module itb_irq_ctrl (
  input  wire logic             CLK_SYS,
  input  wire logic             ARST_N,
  input  wire logic             CLK_EN,
  // Avalon-MM slave
  input  wire logic [7:0]       AVS_ADDRESS,
  input  wire logic             AVS_READ,
  input  wire logic             AVS_WRITE,
  input  wire logic [31:0]      AVS_WRITEDATA,
  input  wire logic [3:0]       AVS_BYTEENABLE,
  output logic [31:0]           AVS_READDATA,
  output logic                  AVS_WAITREQUEST,
  // Asynchronous levels
  input  wire logic             CMP_OUT,
  input  wire logic             LOW_VOLT_OUT,
  input  wire logic             SUB_CLK,
  // Same-clock peripheral events
  input  wire itb_pkg::itb_evt_t EVT_IN,
  // Program sequencer side
  input  wire logic             STACK_FULL,
  input  wire logic             RET_FROM_IRQ,
  output logic                  VEC_CALL,
  output logic [3:0]            VEC_ID,
  output logic                  WAKE,
  output logic                  LXT_LOW_POWER
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  itb_pkg::itb_bus_st_t bus_st_ff;
  itb_pkg::itb_bus_st_t nxt_bus_st;
  logic [31:0] rdata_ff;
  logic [31:0] rd_mux;
  logic [31:0] wmask;
  logic        bus_req;
  logic        bus_acc;
  logic        wr_enable;
  logic        wr_flags;
  logic        wr_global;
  logic        wr_group;
  logic        wr_tb_ctl;

  logic [8:0]  enable_ff;
  logic [8:0]  flag_ff;
  logic [8:0]  nxt_flag;
  logic [8:0]  flag_set;
  logic [8:0]  svc_clr;
  logic [8:0]  eligible;
  logic        gie_ff;
  logic        nxt_gie;
  logic [3:0]  grp_en_ff;
  logic [3:0]  grp_flag_ff;
  logic [3:0]  nxt_grp_flag;
  logic [3:0]  grp_set;
  logic        grp4_live;
  logic [7:0]  tb_ctl_ff;

  logic        cmp_s1_ff;
  logic        cmp_s2_ff;
  logic        cmp_d_ff;
  logic        lowv_s1_ff;
  logic        lowv_s2_ff;
  logic        lowv_d_ff;
  logic        sub_s1_ff;
  logic        sub_s2_ff;
  logic        sub_d_ff;
  logic [3:0]  timer_d_ff;
  logic [3:0]  timer_rise;
  logic [1:0]  presc_ff;

  logic        tb_tick;
  logic        tb0_ovf;
  logic        tb1_ovf;
  logic [14:0] tb_count;

  logic        svc;
  logic [3:0]  svc_id;
  logic        vec_call_ff;
  logic [3:0]  vec_id_ff;
  logic        wake_ff;

  // ----------------------------------------------------------------
  // Byte lane mask for register writes
  // ----------------------------------------------------------------
  assign wmask = {{8{AVS_BYTEENABLE[3]}}, {8{AVS_BYTEENABLE[2]}},
                  {8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};

  // ----------------------------------------------------------------
  // Avalon slave, one wait state per access
  // ----------------------------------------------------------------
  assign bus_req = AVS_READ || AVS_WRITE;
  assign bus_acc = bus_req && CLK_EN && (bus_st_ff == itb_pkg::BUS_ACK);
  assign AVS_WAITREQUEST = bus_req && !bus_acc;
  assign AVS_READDATA    = rdata_ff;

  // Next bus state
  always_comb begin
    nxt_bus_st = bus_st_ff;
    case (bus_st_ff)
      itb_pkg::BUS_IDLE: begin
        if (bus_req) begin
          nxt_bus_st = itb_pkg::BUS_ACK;
        end
      end
      itb_pkg::BUS_ACK: begin
        nxt_bus_st = itb_pkg::BUS_IDLE;
      end
      default: begin
        nxt_bus_st = itb_pkg::BUS_IDLE;
      end
    endcase
  end

  // Bus state register
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      bus_st_ff <= itb_pkg::BUS_IDLE;
    end else if (CLK_EN) begin
      bus_st_ff <= nxt_bus_st;
    end
  end

  // Write strobes, effective on the accepting edge
  assign wr_enable = bus_acc && AVS_WRITE &&
                     (AVS_ADDRESS == itb_pkg::REG_ENABLE_OFS);
  assign wr_flags  = bus_acc && AVS_WRITE &&
                     (AVS_ADDRESS == itb_pkg::REG_FLAGS_OFS);
  assign wr_global = bus_acc && AVS_WRITE &&
                     (AVS_ADDRESS == itb_pkg::REG_GLOBAL_OFS);
  assign wr_group  = bus_acc && AVS_WRITE &&
                     (AVS_ADDRESS == itb_pkg::REG_GROUP4_OFS);
  assign wr_tb_ctl = bus_acc && AVS_WRITE &&
                     (AVS_ADDRESS == itb_pkg::REG_TB_CTL_OFS);

  // Read multiplexer, unmapped reads as zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (AVS_ADDRESS)
      itb_pkg::REG_ENABLE_OFS: rd_mux[8:0] = enable_ff;
      itb_pkg::REG_FLAGS_OFS:  rd_mux[8:0] = flag_ff;
      itb_pkg::REG_GLOBAL_OFS: begin
        rd_mux[itb_pkg::GLOBAL_EN_BIT]  = gie_ff;
        rd_mux[itb_pkg::GLOBAL_STK_BIT] = STACK_FULL;
      end
      itb_pkg::REG_GROUP4_OFS: rd_mux[7:0] = {grp_flag_ff, grp_en_ff};
      itb_pkg::REG_TB_CTL_OFS: rd_mux[7:0] = tb_ctl_ff;
      itb_pkg::REG_STATUS_OFS: begin
        rd_mux[14:0] = tb_count;
        rd_mux[itb_pkg::STAT_CMP_BIT] = cmp_d_ff;
        rd_mux[itb_pkg::STAT_VEC_LSB +: 4] = vec_id_ff;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data captured in the wait cycle, held until next read
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      rdata_ff <= 32'h0000_0000;
    end else if (CLK_EN && AVS_READ &&
                 (bus_st_ff == itb_pkg::BUS_IDLE)) begin
      rdata_ff <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // Input synchronisers for pins and the sub clock
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      cmp_s1_ff  <= 1'b0;
      cmp_s2_ff  <= 1'b0;
      lowv_s1_ff <= 1'b0;
      lowv_s2_ff <= 1'b0;
      sub_s1_ff  <= 1'b0;
      sub_s2_ff  <= 1'b0;
    end else if (CLK_EN) begin
      cmp_s1_ff  <= CMP_OUT;
      cmp_s2_ff  <= cmp_s1_ff;
      lowv_s1_ff <= LOW_VOLT_OUT;
      lowv_s2_ff <= lowv_s1_ff;
      sub_s1_ff  <= SUB_CLK;
      sub_s2_ff  <= sub_s1_ff;
    end
  end

  // Delayed copies for edge detection
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      cmp_d_ff   <= 1'b0;
      lowv_d_ff  <= 1'b0;
      sub_d_ff   <= 1'b0;
      timer_d_ff <= 4'h0;
    end else if (CLK_EN) begin
      cmp_d_ff   <= cmp_s2_ff;
      lowv_d_ff  <= lowv_s2_ff;
      sub_d_ff   <= sub_s2_ff;
      timer_d_ff <= EVT_IN.timer_grp_req;
    end
  end

  assign timer_rise = EVT_IN.timer_grp_req & ~timer_d_ff;

  // ----------------------------------------------------------------
  // Time base clock and divider
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      presc_ff <= 2'h0;
    end else if (CLK_EN) begin
      presc_ff <= presc_ff + 2'h1;
    end
  end

  // Sub clock rising edge or system clock over four
  assign tb_tick = tb_ctl_ff[itb_pkg::TB_CKSEL_BIT]
                   ? (presc_ff == itb_pkg::SYS_PRESC_LAST)
                   : (sub_s2_ff && !sub_d_ff);

  itb_tb_div u_tb_div (
    .clk         (CLK_SYS),
    .arst_n      (ARST_N),
    .clk_en      (CLK_EN),
    .run         (tb_ctl_ff[itb_pkg::TB_RUN_BIT]),
    .tick        (tb_tick),
    .zero_period (tb_ctl_ff[itb_pkg::TB_ZERO_LSB +: 3]),
    .one_period  (tb_ctl_ff[itb_pkg::TB_ONE_LSB +: 2]),
    .zero_ovf    (tb0_ovf),
    .one_ovf     (tb1_ovf),
    .count       (tb_count)
  );

  // Time base control register
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      tb_ctl_ff <= itb_pkg::TB_CTL_RESET;
    end else if (CLK_EN && wr_tb_ctl) begin
      tb_ctl_ff <= (tb_ctl_ff & ~wmask[7:0]) |
                   (AVS_WRITEDATA[7:0] & wmask[7:0]);
    end
  end

  assign LXT_LOW_POWER = tb_ctl_ff[itb_pkg::TB_LXT_LP_BIT];

  // ----------------------------------------------------------------
  // Fourth group sources: low voltage, memory, serial, second port
  // ----------------------------------------------------------------
  assign grp_set[itb_pkg::GRP_LOWV_EN] = lowv_s2_ff && !lowv_d_ff;
  assign grp_set[itb_pkg::GRP_EEP_EN]  = EVT_IN.eep_wr_done;
  assign grp_set[itb_pkg::GRP_SER_EN]  = EVT_IN.serial_done;
  assign grp_set[itb_pkg::GRP_SPI2_EN] = EVT_IN.spi2_done;

  // Source flags: software write, set wins, never auto-cleared
  always_comb begin
    nxt_grp_flag = grp_flag_ff;
    if (wr_group) begin
      nxt_grp_flag = AVS_BYTEENABLE[0] ? AVS_WRITEDATA[7:4] : grp_flag_ff;
    end
    nxt_grp_flag = nxt_grp_flag | grp_set;
  end

  // Group enables and flags
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      grp_en_ff   <= itb_pkg::GROUP_RESET;
      grp_flag_ff <= itb_pkg::GROUP_RESET;
    end else if (CLK_EN) begin
      if (wr_group && AVS_BYTEENABLE[0]) begin
        grp_en_ff <= AVS_WRITEDATA[3:0];
      end
      grp_flag_ff <= nxt_grp_flag;
    end
  end

  // A grouped source with its own enable may vector
  assign grp4_live = |(grp_flag_ff & grp_en_ff);

  // ----------------------------------------------------------------
  // Main request flags in priority order
  // ----------------------------------------------------------------
  assign flag_set[itb_pkg::SRC_CMP] = cmp_s2_ff ^ cmp_d_ff;
  assign flag_set[4:1] = timer_rise;
  assign flag_set[itb_pkg::SRC_GRP4] = |grp_set;
  assign flag_set[itb_pkg::SRC_ADC] = EVT_IN.adc_done;
  assign flag_set[itb_pkg::SRC_TB0] = tb0_ovf;
  assign flag_set[itb_pkg::SRC_TB1] = tb1_ovf;

  // Eligible requests; fourth group also needs a live source
  always_comb begin
    eligible = flag_ff & enable_ff;
    eligible[itb_pkg::SRC_GRP4] = eligible[itb_pkg::SRC_GRP4] && grp4_live;
  end

  // Fixed priority pick, lowest index first
  always_comb begin
    svc_id = 4'h0;
    for (int i = itb_pkg::NUM_SRC - 1; i >= 0; i--) begin
      if (eligible[i]) begin
        svc_id = 4'(i);
      end
    end
  end

  // Service only with global enable and stack room
  assign svc = CLK_EN && gie_ff && !STACK_FULL && (|eligible);

  // Clear only the serviced flag
  always_comb begin
    svc_clr = 9'h000;
    if (svc) begin
      svc_clr[svc_id] = 1'b1;
    end
  end

  // Next flags: write, then auto clear, event set wins
  always_comb begin
    nxt_flag = flag_ff;
    if (wr_flags) begin
      nxt_flag = (flag_ff & ~wmask[8:0]) | (AVS_WRITEDATA[8:0] & wmask[8:0]);
    end
    nxt_flag = (nxt_flag & ~svc_clr) | flag_set;
  end

  // Enable and flag registers
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      enable_ff <= itb_pkg::ENABLE_RESET;
      flag_ff   <= itb_pkg::FLAGS_RESET;
    end else if (CLK_EN) begin
      if (wr_enable) begin
        enable_ff <= (enable_ff & ~wmask[8:0]) |
                     (AVS_WRITEDATA[8:0] & wmask[8:0]);
      end
      flag_ff <= nxt_flag;
    end
  end

  // ----------------------------------------------------------------
  // Global enable: software, return, and service
  // ----------------------------------------------------------------
  always_comb begin
    nxt_gie = gie_ff;
    if (wr_global && AVS_BYTEENABLE[0]) begin
      nxt_gie = AVS_WRITEDATA[itb_pkg::GLOBAL_EN_BIT];
    end
    if (RET_FROM_IRQ) begin
      nxt_gie = 1'b1;
    end
    if (svc) begin
      nxt_gie = 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      gie_ff <= 1'b0;
    end else if (CLK_EN) begin
      gie_ff <= nxt_gie;
    end
  end

  // ----------------------------------------------------------------
  // Vector call, identity and wake outputs
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      vec_call_ff <= 1'b0;
      vec_id_ff   <= 4'h0;
      wake_ff     <= 1'b0;
    end else if (CLK_EN) begin
      vec_call_ff <= svc;
      if (svc) begin
        vec_id_ff <= svc_id;
      end
      wake_ff <= (|(nxt_flag & ~flag_ff)) ||
                 (|(nxt_grp_flag & ~grp_flag_ff));
    end
  end

  assign VEC_CALL = vec_call_ff;
  assign VEC_ID   = vec_id_ff;
  assign WAKE     = wake_ff;

endmodule

// File: tb/itb_irq_chk.sv
// Port assertions for the interrupt and time base block
`timescale 1ns/1ps
module itb_irq_chk (
  input wire logic        CLK_SYS,
  input wire logic        ARST_N,
  input wire logic        CLK_EN,
  input wire logic [7:0]  AVS_ADDRESS,
  input wire logic        AVS_READ,
  input wire logic        AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0]  AVS_BYTEENABLE,
  input wire logic        AVS_WAITREQUEST,
  input wire logic        STACK_FULL,
  input wire logic        RET_FROM_IRQ,
  input wire logic        VEC_CALL,
  input wire logic [3:0]  VEC_ID,
  input wire logic        LXT_LOW_POWER
);
  logic armed_ff;
  logic wr_acc;
  logic wd3;

  default clocking @(posedge CLK_SYS);
  endclocking
  default disable iff (!ARST_N);

  // Accepted write and its bit 3
  assign wr_acc = AVS_WRITE && !AVS_WAITREQUEST && CLK_EN;
  assign wd3    = AVS_WRITEDATA[3];

  // Set once a write or a return could have enabled service
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) armed_ff <= 1'b0;
    else if (wr_acc || RET_FROM_IRQ) armed_ff <= 1'b1;
  end

  call_needs_en_a:
    assert property (VEC_CALL |-> armed_ff)
    else $error("vector call before any enable");
  stack_block_a:
    assert property (STACK_FULL && CLK_EN |=> !VEC_CALL)
    else $error("vector call while stack full");
  no_nest_a:
    assert property (VEC_CALL && !RET_FROM_IRQ && !AVS_WRITE ##1
      !RET_FROM_IRQ && !AVS_WRITE |=> !VEC_CALL)
    else $error("second call without global enable");
  vec_pulse_a:
    assert property (VEC_CALL |=> !VEC_CALL)
    else $error("vector call longer than one cycle");
  vec_hold_a:
    assert property ($changed(VEC_ID) |-> VEC_CALL)
    else $error("vector id moved without a call");
  vec_legal_a:
    assert property (VEC_CALL |-> VEC_ID <= 4'h8)
    else $error("vector id out of range");
  lxt_follow_a:
    assert property (wr_acc && AVS_ADDRESS == 8'h10 && AVS_BYTEENABLE[0]
      |-> ##2 LXT_LOW_POWER == $past(wd3, 2))
    else $error("low power output not following control");
  bus_wait_a:
    assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST && CLK_EN
      |=> !AVS_WAITREQUEST)
    else $error("more than one wait state");

  cover property (VEC_CALL && VEC_ID == 4'h5);
  cover property (VEC_CALL && VEC_ID == 4'h8);
  cover property (STACK_FULL && !VEC_CALL);
endmodule

bind itb_irq_ctrl itb_irq_chk u_chk (.*);

// File: tb/itb_cpu_model.sv
// Program sequencer stand-in answering vector calls
`timescale 1ns/1ps
module itb_cpu_model (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic vec_call,
  input  wire logic auto_ret,
  input  wire logic slow,
  input  wire logic stk_req,
  output logic      stack_full,
  output logic      ret_pulse
);
  logic [4:0] wait_ff;
  logic       busy_ff;

  // Stack level follows the bench request
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) stack_full <= 1'b0;
    else stack_full <= stk_req;
  end

  // Return from service after a short or long routine
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_ff   <= 1'b0;
      wait_ff   <= 5'h00;
      ret_pulse <= 1'b0;
    end else begin
      ret_pulse <= 1'b0;
      if (vec_call && auto_ret) begin
        busy_ff <= 1'b1;
        wait_ff <= slow ? 5'h14 : 5'h01;
      end else if (busy_ff && wait_ff == 5'h00) begin
        busy_ff   <= 1'b0;
        ret_pulse <= 1'b1;
      end else if (busy_ff) begin
        wait_ff <= wait_ff - 5'h01;
      end
    end
  end
endmodule

// File: tb/testbench.sv
// Self-checking bench for the interrupt and time base block
`timescale 1ns/1ps
module testbench;
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  logic [7:0]        adr = 8'h00;
  logic              rd = 1'b0;
  logic              wr = 1'b0;
  logic [31:0]       wdat = 32'h0;
  logic [31:0]       rdat;
  logic              wreq, sfull, ret, vcall, wake, lxt;
  logic              cmp = 1'b0;
  logic              lowv = 1'b0;
  logic              auto_ret = 1'b0;
  logic              slow = 1'b0;
  logic              sf_req = 1'b0;
  logic              en = 1'b1;
  logic [3:0]        be = 4'hf;
  logic              sub = 1'b0;
  logic              sub_run = 1'b1;
  logic [2:0]        sdiv = 3'h0;
  itb_pkg::itb_evt_t evt = '0;
  logic [3:0]        vid;
  logic [3:0]        expq[$];
  int                bad_count = 0, n_compared = 0, seed = 32'h37d4;
  int                cyc = 0, lastc = 0, prevc = 0, wakes = 0;
  int                i, k, w0;
  logic [8:0]        gm[4] = '{9'h100, 9'h004, 9'h002, 9'h001};
  logic [7:0]        tctl[4] = '{8'hc0, 8'hc1, 8'h80, 8'hc0};
  logic [8:0]        ten[4] = '{9'h080, 9'h080, 9'h080, 9'h100};
  int                gap[4] = '{1024, 2048, 4096, 16384};

  // Clock
  initial forever #2 clk = ~clk;

  // Sub clock, sixteen system clocks per period
  always @(posedge clk) begin
    sdiv <= sdiv + 3'h1;
    if (sdiv == 3'h7 && sub_run) sub <= ~sub;
  end

  itb_irq_ctrl DUT (.CLK_SYS(clk), .ARST_N(rst_n), .CLK_EN(en),
    .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(be), .AVS_READDATA(rdat),
    .AVS_WAITREQUEST(wreq), .CMP_OUT(cmp), .LOW_VOLT_OUT(lowv),
    .SUB_CLK(sub), .EVT_IN(evt), .STACK_FULL(sfull),
    .RET_FROM_IRQ(ret), .VEC_CALL(vcall), .VEC_ID(vid), .WAKE(wake),
    .LXT_LOW_POWER(lxt));

  itb_cpu_model u_cpu (.clk(clk), .arst_n(rst_n), .vec_call(vcall),
    .auto_ret(auto_ret), .slow(slow), .stk_req(sf_req),
    .stack_full(sfull), .ret_pulse(ret));

  task automatic test_done;
    $display("compared %0d bad %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Avalon master: hold until waitrequest low at a rising edge
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int  n;
    logic ok;
    n = 0;
    ok = 1'b0;
    rd <= !w;
    wr <= w;
    adr <= a;
    wdat <= d;
    while (!ok) begin
      @(negedge clk) ok = (wreq === 1'b0);
      @(posedge clk);
      n++;
      if (n > 50) begin
        bad_count++;
        test_done();
      end
    end
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask

  // One-cycle event pulse; bit 8 is the low supply level
  task automatic ev(input logic [8:0] m);
    lowv <= m[8];
    evt <= itb_pkg::itb_evt_t'(m[7:0]);
    @(posedge clk);
    lowv <= 1'b0;
    evt <= '0;
    @(posedge clk);
  endtask

  task automatic drain(input int n);
    for (int j = 0; j < n && expq.size() != 0; j++) @(posedge clk);
    if (expq.size() != 0) begin
      bad_count++;
      test_done();
    end
  endtask

  // Watch calls against the noted vectors, count wakes
  always @(negedge clk) begin
    cyc++;
    if (wake === 1'b1) wakes++;
    if (vcall === 1'b1) begin
      prevc = lastc;
      lastc = cyc;
      if (expq.size() == 0) chk(32'h1, 32'h0);
      else chk(vid, expq.pop_front());
    end
  end

  // ----------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rchk(8'h10, 32'h37);
    rchk(8'h18, 32'h0);
    rchk(8'h08, 32'h0);
    chk(lxt, 1'b0);
    // Frozen clock enable must swallow a converter event
    en <= 1'b0;
    ev(9'h008);
    en <= 1'b1;
    rchk(8'h04, 32'h0);
    wreg(8'h10, 32'h3f);
    repeat (2) @(posedge clk);
    chk(lxt, 1'b1);
    wreg(8'h10, 32'h37);
    // Disabled low lane leaves control untouched
    be <= 4'he;
    wreg(8'h10, 32'h00);
    be <= 4'hf;
    rchk(8'h10, 32'h37);
    wreg(8'h00, 32'h1ff);
    wreg(8'h0c, 32'h0f);
    w0 = wakes;
    ev(9'h008);
    repeat (3) @(posedge clk);
    chk(wakes - w0, 1);
    rchk(8'h04, 32'h40);
    expq.push_back(4'h6);
    wreg(8'h08, 32'h1);
    drain(20);
    rchk(8'h04, 32'h0);
    rchk(8'h08, 32'h0);
    // Two pending, slow return in between
    auto_ret <= 1'b1;
    slow <= 1'b1;
    cmp <= 1'b1;
    ev(9'h008);
    repeat (5) @(posedge clk);
    expq.push_back(4'h0);
    expq.push_back(4'h6);
    wreg(8'h08, 32'h1);
    drain(80);
    rchk(8'h04, 32'h0);
    slow <= 1'b0;
    sf_req <= 1'b1;
    repeat (2) @(posedge clk);
    ev(9'h008);
    repeat (30) @(posedge clk);
    rchk(8'h08, 32'h3);
    expq.push_back(4'h6);
    sf_req <= 1'b0;
    drain(20);
    // Grouped sources keep their own flags
    for (i = 0; i < 4; i++) begin
      expq.push_back(4'h5);
      ev(gm[i]);
      drain(40);
      rchk(8'h0c, 32'h0f | (32'h10 << i));
      wreg(8'h0c, 32'h0f);
    end
    wreg(8'h0c, 32'h0d);
    ev(9'h004);
    repeat (10) @(posedge clk);
    rchk(8'h0c, 32'h2d);
    wreg(8'h0c, 32'h0f);
    wreg(8'h04, 32'h0);
    for (i = 0; i < 4; i++) begin
      k = $unsigned($random(seed)) % 4;
      expq.push_back(4'(k + 1));
      ev(9'h010 << k);
      drain(40);
    end
    // Time base periods from the control fields
    for (i = 0; i < 4; i++) begin
      wreg(8'h00, 32'(ten[i]));
      expq.push_back(ten[i][8] ? 4'h8 : 4'h7);
      expq.push_back(ten[i][8] ? 4'h8 : 4'h7);
      wreg(8'h10, 32'(tctl[i]));
      drain(40000);
      chk(lastc - prevc, gap[i]);
      wreg(8'h10, 32'h40);
    end
    wreg(8'h04, 32'h0);
    wreg(8'h00, 32'h80);
    sub_run <= 1'b0;
    for (i = 0; i < 2; i++) begin
      wreg(8'h10, i ? 32'h80 : 32'h40);
      repeat (1100) @(posedge clk);
      rchk(8'h14, {4'h0, 4'h8, 7'h0, cmp, 16'h0});
    end
    test_done();
  end
endmodule
